// ### rtl/pob_pkg.sv
/*
 Package for the PWM output configuration bank: register offsets,
 field positions, reset values and timing counts.
 Assumes a 20 MHz core clock.
*/
package pob_pkg;
   // Register offsets
   localparam logic [15:0] ADDR_DUTY_LO = 16'h0060;
   localparam logic [15:0] ADDR_DUTY_HI = 16'h0062;
   localparam logic [15:0] ADDR_DIAG_LO = 16'h0064;
   localparam logic [15:0] ADDR_DIAG_HI = 16'h0066;
   localparam logic [15:0] ADDR_PRESC = 16'h0068;
   localparam logic [15:0] ADDR_PERIOD = 16'h006a;
   localparam logic [15:0] ADDR_CHKSUM = 16'h006e;
   localparam logic [15:0] ADDR_MODE = 16'h0098;
   // Field widths and positions
   localparam int DUTY_W = 14;
   localparam int PRESC_W = 8;
   localparam int POS_RST_THR = 13;
   localparam int POS_CLK_SEL = 12;
   localparam int POS_UPD_RATE = 11;
   localparam int POS_LUT_LO = 8;
   localparam int POS_IFMD_B_LO = 4;
   localparam int POS_IFMD_A = 0;
   // Writable bits of the mode word
   localparam logic [15:0] MODE_MASK = 16'h3b31;
   // Reset values
   localparam logic [15:0] RST_DUTY_LO = 16'h0000;
   localparam logic [15:0] RST_DUTY_HI = 16'h3fff;
   localparam logic [15:0] RST_DIAG_LO = 16'h0000;
   localparam logic [15:0] RST_DIAG_HI = 16'h3fff;
   localparam logic [15:0] RST_PRESC = 16'h000c;
   localparam logic [15:0] RST_PERIOD = 16'h3c18;
   localparam logic [15:0] RST_CHKSUM = 16'h0000;
   localparam logic [15:0] RST_MODE = 16'h0000;
   // Timing
   localparam int CLK_HZ = 20000000;
   localparam int CLK_PERIOD_PS = 50000;
   localparam int BASE_HZ = 4000000;
   localparam int TICK_DIV = CLK_HZ / BASE_HZ;
   localparam int UPD_FAST_PS = 25600000;
   localparam int UPD_SLOW_PS = 51200000;
   localparam int UPD_FAST_CYC = UPD_FAST_PS / CLK_PERIOD_PS;
   localparam int UPD_SLOW_CYC = UPD_SLOW_PS / CLK_PERIOD_PS;
   // Look-up table ranges
   typedef enum logic [1:0] {
      POB_LUT_OFF,
      POB_LUT_360,
      POB_LUT_180,
      POB_LUT_90
   } pob_lut_t;
endpackage

// ### rtl/pob_bank.sv
/*
 PWM output configuration bank with its PWM generator and mode word.
 Assumes the register port, angle and diagnostic inputs come from
 logic on i_clock; only i_rstn is asynchronous.
*/
// Summary of operation
// - PWM output acts only when the interface select chooses PWM.
// - Data duty lower bound is a 14-bit code, 0..16383 for 0..100%.
// - Data duty upper bound is a 14-bit code with the same mapping.
// - Low diagnostic duty level is a 14-bit code.
// - High diagnostic duty level is a 14-bit code.
// - PWM frequency is 4 MHz over (1 + prescaler) times period.
// - Angle update every 25.6 us with rate bit 0, 51.2 us with 1.
// - Two-bit table mode: off, 360, 180 or 90 degree range.
// - Reset threshold bit: 0 selects below 3.0 V, 1 below 4.2 V.
`timescale 1ns/1ps
`default_nettype none
module pob_bank
   import pob_pkg::*;
(
   input wire logic i_clock,
   input wire logic i_rstn,
   input wire logic i_prog_mode,
   input wire logic i_wr_en,
   input wire logic i_rd_en,
   input wire logic [15:0] i_addr,
   input wire logic [15:0] i_wdata,
   output logic [15:0] o_rdata,
   output logic o_rd_valid,
   input wire logic i_if_sel_pwm,
   input wire logic [DUTY_W-1:0] i_angle,
   input wire logic i_diag_req,
   input wire logic i_diag_high,
   output logic o_pwm,
   output logic o_angle_update,
   output logic o_lut_enable,
   output pob_lut_t o_lut_range,
   output logic o_reset_thr_high
);
   logic rst_meta_reg;
   logic rst_sync_reg;
   logic [DUTY_W-1:0] duty_lo_reg;
   logic [DUTY_W-1:0] duty_hi_reg;
   logic [DUTY_W-1:0] diag_lo_reg;
   logic [DUTY_W-1:0] diag_hi_reg;
   logic [PRESC_W-1:0] presc_reg;
   logic [DUTY_W-1:0] period_reg;
   logic [15:0] chksum_reg;
   logic [15:0] mode_reg;
   logic [2:0] tick_cnt_reg;
   logic tick;
   logic [PRESC_W-1:0] pre_cnt_reg;
   logic [DUTY_W-1:0] per_cnt_reg;
   logic [DUTY_W-1:0] high_reg;
   logic [DUTY_W-1:0] high_next;
   logic [DUTY_W-1:0] duty_now;
   logic [DUTY_W-1:0] span;
   logic [2*DUTY_W-1:0] scaled;
   logic [2*DUTY_W-1:0] on_prod;
   logic [9:0] upd_cnt_reg;
   logic [9:0] upd_limit;
   logic wr_ok;
   logic per_wrap;

   // Reset release through two flops
   always_ff @(posedge i_clock or negedge i_rstn) begin
      if (!i_rstn) begin
         rst_meta_reg <= 1'b0;
         rst_sync_reg <= 1'b0;
      end else begin
         rst_meta_reg <= 1'b1;
         rst_sync_reg <= rst_meta_reg;
      end
   end

   // Accesses count only in programming mode
   assign wr_ok = i_wr_en && i_prog_mode;

   // Register writes; reserved bits are not stored
   always_ff @(posedge i_clock or negedge rst_sync_reg) begin
      if (!rst_sync_reg) begin
         duty_lo_reg <= RST_DUTY_LO[DUTY_W-1:0];
         duty_hi_reg <= RST_DUTY_HI[DUTY_W-1:0];
         diag_lo_reg <= RST_DIAG_LO[DUTY_W-1:0];
         diag_hi_reg <= RST_DIAG_HI[DUTY_W-1:0];
         presc_reg <= RST_PRESC[PRESC_W-1:0];
         period_reg <= RST_PERIOD[DUTY_W-1:0];
         chksum_reg <= RST_CHKSUM;
         mode_reg <= RST_MODE;
      end else if (wr_ok) begin
         if (i_addr == ADDR_DUTY_LO) begin
            duty_lo_reg <= i_wdata[DUTY_W-1:0];
         end else if (i_addr == ADDR_DUTY_HI) begin
            duty_hi_reg <= i_wdata[DUTY_W-1:0];
         end else if (i_addr == ADDR_DIAG_LO) begin
            diag_lo_reg <= i_wdata[DUTY_W-1:0];
         end else if (i_addr == ADDR_DIAG_HI) begin
            diag_hi_reg <= i_wdata[DUTY_W-1:0];
         end else if (i_addr == ADDR_PRESC) begin
            presc_reg <= i_wdata[PRESC_W-1:0];
         end else if (i_addr == ADDR_PERIOD) begin
            period_reg <= i_wdata[DUTY_W-1:0];
         end else if (i_addr == ADDR_CHKSUM) begin
            chksum_reg <= i_wdata; // Whole word, CRC in low byte
         end else if (i_addr == ADDR_MODE) begin
            mode_reg <= i_wdata & MODE_MASK;
         end
      end
   end

   // Read data, one cycle after the request; unmapped reads as zero
   always_ff @(posedge i_clock or negedge rst_sync_reg) begin
      if (!rst_sync_reg) begin
         o_rdata <= 16'h0000;
         o_rd_valid <= 1'b0;
      end else begin
         o_rd_valid <= i_rd_en && i_prog_mode;
         if (!(i_rd_en && i_prog_mode)) begin
            o_rdata <= o_rdata;
         end else if (i_addr == ADDR_DUTY_LO) begin
            o_rdata <= {2'h0, duty_lo_reg};
         end else if (i_addr == ADDR_DUTY_HI) begin
            o_rdata <= {2'h0, duty_hi_reg};
         end else if (i_addr == ADDR_DIAG_LO) begin
            o_rdata <= {2'h0, diag_lo_reg};
         end else if (i_addr == ADDR_DIAG_HI) begin
            o_rdata <= {2'h0, diag_hi_reg};
         end else if (i_addr == ADDR_PRESC) begin
            o_rdata <= {8'h00, presc_reg};
         end else if (i_addr == ADDR_PERIOD) begin
            o_rdata <= {2'h0, period_reg};
         end else if (i_addr == ADDR_CHKSUM) begin
            o_rdata <= chksum_reg;
         end else if (i_addr == ADDR_MODE) begin
            o_rdata <= mode_reg;
         end else begin
            o_rdata <= 16'h0000;
         end
      end
   end

   // Mode word decode
   assign o_reset_thr_high = mode_reg[POS_RST_THR];
   assign o_lut_range = pob_lut_t'(mode_reg[POS_LUT_LO +: 2]);
   assign o_lut_enable = (o_lut_range != POB_LUT_OFF);

   // Angle update strobe, period chosen by the rate bit
   assign upd_limit = mode_reg[POS_UPD_RATE] ? 10'(UPD_SLOW_CYC - 1) : 10'(UPD_FAST_CYC - 1);
   always_ff @(posedge i_clock or negedge rst_sync_reg) begin
      if (!rst_sync_reg) begin
         upd_cnt_reg <= 10'h000;
         o_angle_update <= 1'b0;
      end else begin
         o_angle_update <= (upd_cnt_reg >= upd_limit);
         upd_cnt_reg <= (upd_cnt_reg >= upd_limit) ? 10'h000 : upd_cnt_reg + 10'h001;
      end
   end

   // 4 MHz timebase from the core clock
   assign tick = (tick_cnt_reg == 3'(TICK_DIV - 1));
   always_ff @(posedge i_clock or negedge rst_sync_reg) begin
      if (!rst_sync_reg) begin
         tick_cnt_reg <= 3'h0;
      end else begin
         tick_cnt_reg <= tick ? 3'h0 : tick_cnt_reg + 3'h1;
      end
   end

   // Prescaler and period counters; a zero period acts as one
   // A prescaler lowered mid-count wraps at once instead of running round
   assign per_wrap = tick && (pre_cnt_reg >= presc_reg)
      && (per_cnt_reg + 14'h0001 >= period_reg);
   always_ff @(posedge i_clock or negedge rst_sync_reg) begin
      if (!rst_sync_reg) begin
         pre_cnt_reg <= '0;
         per_cnt_reg <= '0;
      end else if (tick) begin
         if (pre_cnt_reg >= presc_reg) begin
            pre_cnt_reg <= '0;
            per_cnt_reg <= per_wrap ? '0 : per_cnt_reg + 14'h0001;
         end else begin
            pre_cnt_reg <= pre_cnt_reg + 8'h01;
         end
      end
   end

   // Duty code: diagnostic level or angle scaled between the bounds
   always_comb begin
      span = (duty_hi_reg > duty_lo_reg) ? duty_hi_reg - duty_lo_reg : 14'h0000;
      scaled = span * i_angle;
      if (i_diag_req) begin
         duty_now = i_diag_high ? diag_hi_reg : diag_lo_reg;
      end else begin
         duty_now = duty_lo_reg + scaled[2*DUTY_W-1:DUTY_W];
      end
      on_prod = duty_now * period_reg;
      high_next = on_prod[2*DUTY_W-1:DUTY_W];
   end

   // High time is taken at each period start so a period is never torn
   always_ff @(posedge i_clock or negedge rst_sync_reg) begin
      if (!rst_sync_reg) begin
         high_reg <= '0;
      end else if (per_wrap) begin
         high_reg <= high_next;
      end
   end

   // Output, held low unless PWM is the chosen interface
   always_ff @(posedge i_clock or negedge rst_sync_reg) begin
      if (!rst_sync_reg) begin
         o_pwm <= 1'b0;
      end else begin
         o_pwm <= i_if_sel_pwm && (per_cnt_reg < high_reg);
      end
   end

   // Spacing helper: clocks since the last angle strobe, saturating;
   // the first strobe after reset has no gap before it
   logic [10:0] upd_gap_reg;
   logic upd_seen_reg;
   logic mode_wr_reg;
   always_ff @(posedge i_clock or negedge rst_sync_reg) begin
      if (!rst_sync_reg) begin
         upd_gap_reg <= 11'h000;
         upd_seen_reg <= 1'b0;
      end else if (o_angle_update) begin
         upd_gap_reg <= 11'h001;
         upd_seen_reg <= 1'b1;
      end else if (upd_gap_reg != 11'h7ff) begin
         upd_gap_reg <= upd_gap_reg + 11'h001;
      end
   end

   // A mode write spoils the gap in flight; the write wins over the strobe
   always_ff @(posedge i_clock or negedge rst_sync_reg) begin
      if (!rst_sync_reg) begin
         mode_wr_reg <= 1'b0;
      end else if (wr_ok && i_addr == ADDR_MODE) begin
         mode_wr_reg <= 1'b1;
      end else if (o_angle_update) begin
         mode_wr_reg <= 1'b0;
      end
   end

   // Checks
   default clocking cb @(posedge i_clock); endclocking
   default disable iff (!rst_sync_reg);

   a_pwm_gated: assert property (!i_if_sel_pwm |=> !o_pwm)
      else $error("PWM active while interface not selected");
   a_wr_locked: assert property (i_wr_en && !i_prog_mode
      |=> $stable(mode_reg) && $stable(period_reg) && $stable(presc_reg))
      else $error("Write taken outside programming mode");
   a_duty_lower: assert property (!i_diag_req |-> duty_now >= duty_lo_reg)
      else $error("Data duty below lower bound");
   a_duty_upper: assert property (!i_diag_req && duty_hi_reg >= duty_lo_reg |-> duty_now <= duty_hi_reg)
      else $error("Data duty above upper bound");
   a_diag_low: assert property (i_diag_req && !i_diag_high |-> duty_now == diag_lo_reg)
      else $error("Low diagnostic level not used");
   a_diag_high: assert property (i_diag_req && i_diag_high |-> duty_now == diag_hi_reg)
      else $error("High diagnostic level not used");
   a_tick_period: assert property (tick |=> !tick [*4] ##1 tick)
      else $error("Timebase tick not every five clocks");
   a_upd_fast: assert property (o_angle_update && upd_seen_reg && !mode_wr_reg && !mode_reg[POS_UPD_RATE]
      |-> upd_gap_reg == 11'(UPD_FAST_CYC))
      else $error("Fast angle update spacing wrong");
   a_upd_slow: assert property (o_angle_update && upd_seen_reg && !mode_wr_reg && mode_reg[POS_UPD_RATE]
      |-> upd_gap_reg == 11'(UPD_SLOW_CYC))
      else $error("Slow angle update spacing wrong");
   a_upd_gap: assert property (o_angle_update |=> !o_angle_update [*8])
      else $error("Angle updates too close");
   a_lut_off: assert property (mode_reg[POS_LUT_LO +: 2] == 2'h0 |-> !o_lut_enable)
      else $error("Table enabled in off mode");
   a_rst_thr: assert property (wr_ok && i_addr == ADDR_MODE |=> o_reset_thr_high == $past(i_wdata[13]))
      else $error("Reset threshold not taken from write");

   // Register port, mode decode and counter invariants
   a_rd_gated: assert property (i_rd_en && !i_prog_mode |=> !o_rd_valid)
      else $error("Read answered outside programming mode");
   a_rd_mode: assert property (i_rd_en && i_prog_mode && i_addr == ADDR_MODE
      |=> o_rd_valid && o_rdata == $past(mode_reg))
      else $error("Mode word read back wrong");
   a_presc_wr: assert property (wr_ok && i_addr == ADDR_PRESC |=> presc_reg == $past(i_wdata[PRESC_W-1:0]))
      else $error("Prescaler write not taken");
   a_lut_on: assert property (mode_reg[POS_LUT_LO +: 2] != 2'h0 |-> o_lut_enable)
      else $error("Table disabled in a range mode");
   a_per_on_tick: assert property (!tick |=> $stable(per_cnt_reg))
      else $error("Period count moved off the timebase");
   a_high_hold: assert property (!per_wrap |=> $stable(high_reg))
      else $error("High time changed inside a period");

   // Main scenarios
   c_pwm_high: cover property (i_if_sel_pwm ##1 o_pwm);
   c_period_wrap: cover property (per_wrap);
   c_diag_out: cover property (i_diag_req && per_wrap);
   c_slow_rate: cover property (mode_reg[POS_UPD_RATE] && o_angle_update);
   c_fast_gap: cover property (!mode_reg[POS_UPD_RATE] && o_angle_update && upd_seen_reg && !mode_wr_reg);
endmodule // pob_bank
`default_nettype wire

// ### tb/pob_ecu_model.sv
/*
 Control unit model: times the high phase and the period of the PWM line.
 Assumes o_pwm is a clean register output on i_clock.
*/
`timescale 1ns/1ps
`default_nettype none
module pob_ecu_model (
   input wire logic i_clock,
   input wire logic i_pwm,
   output logic [15:0] o_high,
   output logic [15:0] o_per,
   output logic o_valid
);
   logic last_reg;
   logic [15:0] hcnt_reg;
   logic [15:0] pcnt_reg;
   // Count clocks; each rising edge reports the period just finished
   always_ff @(posedge i_clock) begin
      last_reg <= i_pwm;
      o_valid <= i_pwm && !last_reg;
      if (i_pwm && !last_reg) begin
         o_high <= hcnt_reg;
         o_per <= pcnt_reg;
         hcnt_reg <= 16'h0001;
         pcnt_reg <= 16'h0001;
      end else begin
         hcnt_reg <= hcnt_reg + {15'h0, i_pwm};
         pcnt_reg <= pcnt_reg + 16'h0001;
      end
   end
endmodule // pob_ecu_model
`default_nettype wire

// ### tb/tb_top.sv
/*
 Testbench for the PWM output configuration bank.
 Assumes the bank and the control unit model share one 20 MHz clock.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import pob_pkg::*;
   logic i_clock = 0, i_rstn = 0, i_prog_mode = 1, i_wr_en = 0, i_rd_en = 0;
   logic [15:0] i_addr = 0, i_wdata = 0, o_rdata, h, p, q, w, kp, e;
   logic i_if_sel_pwm = 1, i_diag_req = 0, i_diag_high = 0;
   logic [13:0] i_angle = 0, lo, up;
   logic o_rd_valid, o_pwm, o_angle_update, o_lut_enable, o_reset_thr_high, mv;
   pob_lut_t o_lut_range;
   int error_cnt = 0, tests_run = 0, seed = 91648, n;
   logic [15:0] ad[8] = '{ADDR_DUTY_LO, ADDR_DUTY_HI, ADDR_DIAG_LO, ADDR_DIAG_HI,
      ADDR_PRESC, ADDR_PERIOD, ADDR_CHKSUM, ADDR_MODE};
   logic [15:0] rs[8] = '{RST_DUTY_LO, RST_DUTY_HI, RST_DIAG_LO, RST_DIAG_HI,
      RST_PRESC, RST_PERIOD, RST_CHKSUM, RST_MODE};
   logic [15:0] mk[8] = '{16'h3fff, 16'h3fff, 16'h3fff, 16'h3fff, 16'h00ff,
      16'h3fff, 16'hffff, MODE_MASK};
   pob_bank pob_bank_i (.i_clock(i_clock), .i_rstn(i_rstn), .i_prog_mode(i_prog_mode),
      .i_wr_en(i_wr_en), .i_rd_en(i_rd_en), .i_addr(i_addr), .i_wdata(i_wdata),
      .o_rdata(o_rdata), .o_rd_valid(o_rd_valid), .i_if_sel_pwm(i_if_sel_pwm),
      .i_angle(i_angle), .i_diag_req(i_diag_req), .i_diag_high(i_diag_high),
      .o_pwm(o_pwm), .o_angle_update(o_angle_update), .o_lut_enable(o_lut_enable),
      .o_lut_range(o_lut_range), .o_reset_thr_high(o_reset_thr_high));
   pob_ecu_model pob_ecu_model_i (.i_clock(i_clock), .i_pwm(o_pwm), .o_high(h),
      .o_per(p), .o_valid(mv));
   // Clock of 50 ns
   always #25 i_clock = ~i_clock;
   task automatic complete_run();
      $display("Checks %0d, errors %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [15:0] s, input logic [15:0] x);
      tests_run++;
      if (s !== x) begin
         error_cnt++;
         $display("ERROR %s expected %h seen %h", nm, x, s);
      end
   endtask
   task automatic wr(input logic [15:0] a, input logic [15:0] d, input logic pm);
      @(posedge i_clock);
      #5 {i_wr_en, i_addr, i_wdata, i_prog_mode} = {1'b1, a, d, pm};
      @(posedge i_clock);
      #5 {i_wr_en, i_prog_mode} = 2'b01;
   endtask
   task automatic rd(input logic [15:0] a, input logic pm, output logic [15:0] d);
      @(posedge i_clock);
      #5 {i_rd_en, i_addr, i_prog_mode} = {1'b1, a, pm};
      @(posedge i_clock);
      #5 {i_rd_en, i_prog_mode} = 2'b01;
      chk("rd_valid", {15'h0, o_rd_valid}, {15'h0, pm});
      d = o_rdata;
   endtask
   // Bounded wait for a finished period; the third one is settled
   task automatic meas();
      repeat (3) begin
         n = 0;
         do begin @(posedge i_clock); #5 n++; end while (mv !== 1'b1 && n < 1000);
         if (n == 1000) begin error_cnt++; complete_run(); end
      end
   endtask
   // Bounded wait for the next angle strobe; running out ends the run
   task automatic wait_upd();
      n = 0;
      do begin @(posedge i_clock); #5 n++; end while (o_angle_update !== 1'b1 && n < 1100);
      if (n == 1100) begin error_cnt++; complete_run(); end
   endtask
   function automatic logic [15:0] hi_t(logic [13:0] l, logic [13:0] u, logic [13:0] a);
      logic [27:0] d;
      d = (u > l) ? ((28'(u - l) * a) >> 14) : 28'h0;
      d = d + l;
      return 16'((d * 16) >> 14);
   endfunction
   initial begin
      repeat (2) @(posedge i_clock);
      #5 i_rstn = 1;
      repeat (3) @(posedge i_clock);
      // Reset values, then read-modify-write with reserved, clock select and interface mode bits kept
      for (int k = 0; k < 8; k++) begin
         rd(ad[k], 1, q);
         chk("reset_val", q, rs[k]);
         kp = ~mk[k] | ((k == 7) ? 16'h1031 : 16'h0);
         w = (q & kp) | ($random(seed) & ~kp);
         wr(ad[k], w, 1);
         rd(ad[k], 1, q);
         chk("readback", q, w & mk[k]);
      end
      wr(16'h006c, 16'hffff, 1);
      rd(16'h006c, 1, q);
      chk("unmapped", q, 16'h0000);
      rd(ADDR_PRESC, 1, e);
      wr(ADDR_PRESC, ~e, 0);
      rd(ADDR_PRESC, 0, q);
      rd(ADDR_PRESC, 1, q);
      chk("prog_off_wr", q, e);
      // Mode word decode and angle strobe spacing
      for (int m = 0; m < 4; m++) begin
         rd(ADDR_MODE, 1, q);
         w = (q & 16'h1031) | (16'(m & 1) << 13) | (16'(m >> 1) << 11) | (16'(m) << 8);
         wr(ADDR_MODE, w, 1);
         chk("lut_en", {15'h0, o_lut_enable}, {15'h0, m != 0});
         chk("lut_range", {14'h0, o_lut_range}, 16'(m));
         chk("rst_thr", {15'h0, o_reset_thr_high}, 16'(m & 1));
         repeat (2) begin
            if (o_angle_update !== 1'b1) wait_upd();
            wait_upd();
         end
         chk("upd_gap", 16'(n), 16'((m > 1) ? UPD_SLOW_CYC : UPD_FAST_CYC));
      end
      // PWM: prescaler 1 and period 16 give 160 clocks a period
      wr(ADDR_PRESC, 16'h0001, 1);
      wr(ADDR_PERIOD, 16'h0010, 1);
      wr(ADDR_DIAG_LO, 16'h0800, 1);
      wr(ADDR_DIAG_HI, 16'h3800, 1);
      for (int k = 0; k < 4; k++) begin
         lo = (k == 3) ? 14'h2000 : 14'h1000;
         up = (k == 3) ? 14'h1000 : 14'h3000;
         wr(ADDR_DUTY_LO, {2'h0, lo}, 1);
         wr(ADDR_DUTY_HI, {2'h0, up}, 1);
         i_angle = 14'($random(seed));
         {i_diag_req, i_diag_high} = {k == 1 || k == 2, k == 2};
         e = (k == 1) ? hi_t(14'h0800, 14'h0800, 0) : (k == 2) ? hi_t(14'h3800, 14'h3800, 0)
            : hi_t(lo, up, i_angle);
         meas();
         chk("pwm_high", h, 16'(e * 10));
         chk("pwm_period", p, 16'd160);
      end
      i_if_sel_pwm = 0;
      n = 0;
      repeat (400) begin @(posedge i_clock); #5 n += o_pwm; end
      chk("pwm_off", 16'(n), 16'h0000);
      complete_run();
   end
endmodule // tb_top
`default_nettype wire
